// ### mode_switch_serial_gateway.sv
// Mode control and serial gateway core of the fieldbus adapter.
// Assumes switch and rxd synchronous to clk; reset is the power-on reset.
`timescale 1ns/100ps
module mode_switch_serial_gateway #(
   parameter int LED_PHASE_CYC = gateway_pkg::LED_PHASE_CYC_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Rotary switch
   input wire logic [3:0] mode_switch,
   // Sensor link
   input wire logic rxd,
   input wire logic sensor_link_up,
   output logic pass_through,
   // Mode reporting
   output gateway_pkg::mode_t active_mode,
   output logic proxy_enable,
   output logic cloning_enable,
   output logic gateway_enable,
   output logic fieldbus_enable,
   output logic fw_update_self,
   output logic [15:0] bit_cyc,
   // Message to fieldbus side
   output gateway_pkg::char_t msg_char,
   output gateway_pkg::msg_t msg_end,
   output logic [7:0] msg_mem_rd_data,
   input wire logic [5:0] msg_mem_rd_addr,
   // Status LEDs
   output logic power_led,
   output logic all_leds_flash
);
   logic sampled;
   logic [3:0] switch_at_power;
   logic switch_changed;
   gateway_pkg::mode_t next_mode;
   gateway_pkg::char_t rx_char;
   logic in_frame;
   logic [6:0] msg_len;
   logic [7:0] msg_mem [gateway_pkg::MSG_DEPTH];
   logic [2:0] flashes;
   logic steady;
   logic led_raw;
   logic led_tick;
   logic all_phase;
   logic operational;

   // Decode the power-up position
   always_comb begin
      case (mode_switch)
         gateway_pkg::POS_PROXY: next_mode = gateway_pkg::MODE_PROXY;
         gateway_pkg::POS_GW_FAST: next_mode = gateway_pkg::MODE_GW_FAST;
         gateway_pkg::POS_GW_SLOW: next_mode = gateway_pkg::MODE_GW_SLOW;
         gateway_pkg::POS_FW_SELF: next_mode = gateway_pkg::MODE_FW_SELF;
         gateway_pkg::POS_PASS_THRU: next_mode = gateway_pkg::MODE_PASS_THRU;
         default: next_mode = gateway_pkg::MODE_RESERVED;
      endcase
   end

   // Capture once after reset release; a strap, not a live input
   always_ff @(posedge clk) begin
      if (reset) begin
         sampled <= 1'b0;
         switch_at_power <= 4'h0;
         active_mode <= gateway_pkg::MODE_RESERVED;
      end else if (!sampled) begin
         sampled <= 1'b1;
         switch_at_power <= mode_switch;
         active_mode <= next_mode;
      end
   end

   // Sticky until power cycles; mode itself never follows the switch
   always_ff @(posedge clk) begin
      if (reset) begin
         switch_changed <= 1'b0;
      end else if (sampled && mode_switch != switch_at_power) begin
         switch_changed <= 1'b1;
      end
   end

   // Mode-derived controls; reserved positions enable nothing
   always_ff @(posedge clk) begin
      if (reset) begin
         proxy_enable <= 1'b0;
         cloning_enable <= 1'b0;
         gateway_enable <= 1'b0;
         fieldbus_enable <= 1'b0;
         fw_update_self <= 1'b0;
         pass_through <= 1'b0;
         bit_cyc <= gateway_pkg::BIT_CYC_FAST;
      end else begin
         proxy_enable <= active_mode == gateway_pkg::MODE_PROXY;
         cloning_enable <= active_mode == gateway_pkg::MODE_PROXY;
         gateway_enable <= active_mode == gateway_pkg::MODE_GW_FAST
            || active_mode == gateway_pkg::MODE_GW_SLOW;
         fieldbus_enable <= active_mode == gateway_pkg::MODE_PROXY
            || active_mode == gateway_pkg::MODE_GW_FAST
            || active_mode == gateway_pkg::MODE_GW_SLOW;
         fw_update_self <= active_mode == gateway_pkg::MODE_FW_SELF;
         pass_through <= active_mode == gateway_pkg::MODE_PASS_THRU;
         bit_cyc <= (active_mode == gateway_pkg::MODE_GW_SLOW)
            ? gateway_pkg::BIT_CYC_SLOW : gateway_pkg::BIT_CYC_FAST;
      end
   end

   serial_rx u_rx (
      .clk(clk),
      .reset(reset),
      .bit_cyc(bit_cyc),
      .rxd(rxd),
      .rx_char(rx_char)
   );

   // Framing: delimiters never reach the message
   always_ff @(posedge clk) begin
      if (reset) begin
         in_frame <= 1'b0;
         msg_len <= 7'h00;
         msg_char <= '0;
         msg_end <= '0;
      end else begin
         msg_char.valid <= 1'b0;
         msg_end.done <= 1'b0;
         if (gateway_enable && rx_char.valid) begin
            if (rx_char.data == gateway_pkg::CHAR_STX) begin
               in_frame <= 1'b1;
               msg_len <= 7'h00;
            end else if (rx_char.data == gateway_pkg::CHAR_ETX && in_frame) begin
               in_frame <= 1'b0;
               msg_end.done <= 1'b1;
               msg_end.length <= msg_len;
            end else if (in_frame && msg_len < 7'(gateway_pkg::MSG_DEPTH)) begin
               msg_char <= rx_char;
               msg_len <= msg_len + 7'h01;
            end
         end
      end
   end

   // Message store; overlong strings are truncated at its depth
   always_ff @(posedge clk) begin
      if (gateway_enable && rx_char.valid && in_frame
         && rx_char.data != gateway_pkg::CHAR_STX && rx_char.data != gateway_pkg::CHAR_ETX
         && msg_len < 7'(gateway_pkg::MSG_DEPTH)) begin
         msg_mem[msg_len[5:0]] <= rx_char.data;
      end
      msg_mem_rd_data <= msg_mem[msg_mem_rd_addr];
   end

   // Proxy waits for the sensor; gateway is ready once running
   always_ff @(posedge clk) begin
      if (reset) begin
         operational <= 1'b0;
      end else begin
         operational <= sampled && ((proxy_enable && sensor_link_up) || gateway_enable);
      end
   end

   // Change indication takes precedence over the normal display
   always_comb begin
      steady = 1'b0;
      flashes = gateway_pkg::FLASH_SEARCH;
      if (switch_changed) begin
         flashes = gateway_pkg::FLASH_CHANGED;
      end else if (pass_through) begin
         flashes = gateway_pkg::FLASH_PASS;
      end else if (operational) begin
         steady = 1'b1;
      end
   end

   led_blinker #(
      .PHASE_CYC(LED_PHASE_CYC)
   ) u_led (
      .clk(clk),
      .reset(reset),
      .flashes(flashes),
      .steady(steady),
      .led(led_raw),
      .tick(led_tick)
   );

   // Self update, switch unchanged: every LED toggles in step
   always_ff @(posedge clk) begin
      if (reset) begin
         all_phase <= 1'b0;
      end else if (led_tick) begin
         all_phase <= ~all_phase;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         power_led <= 1'b0;
         all_leds_flash <= 1'b0;
      end else if (fw_update_self && !switch_changed) begin
         power_led <= all_phase;
         all_leds_flash <= all_phase;
      end else begin
         power_led <= led_raw;
         all_leds_flash <= 1'b0;
      end
   end
endmodule

// ### gateway_pkg.sv
// Package: modes, LED timing, serial timing and frame carriers.
// Assumes a 100 MHz system clock and power-on as synchronous reset.
package gateway_pkg;

   typedef enum logic [2:0] {
      MODE_PROXY,
      MODE_GW_FAST,
      MODE_GW_SLOW,
      MODE_FW_SELF,
      MODE_PASS_THRU,
      MODE_RESERVED
   } mode_t;

   localparam logic [3:0] POS_PROXY = 4'h0;
   localparam logic [3:0] POS_GW_FAST = 4'h2;
   localparam logic [3:0] POS_GW_SLOW = 4'h4;
   localparam logic [3:0] POS_FW_SELF = 4'hE;
   localparam logic [3:0] POS_PASS_THRU = 4'hF;

   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_FAST = 57_600;
   localparam int BAUD_SLOW = 9_600;
   localparam logic [15:0] BIT_CYC_FAST = 16'(CLK_HZ / BAUD_FAST);
   localparam logic [15:0] BIT_CYC_SLOW = 16'(CLK_HZ / BAUD_SLOW);

   localparam logic [7:0] CHAR_STX = 8'h02;
   localparam logic [7:0] CHAR_ETX = 8'h03;
   localparam int DATA_BITS = 8;
   localparam int MSG_DEPTH = 64;

   // LED blink phase in ms and its cycle count
   localparam int LED_PHASE_MS = 200;
   localparam int LED_PHASE_CYC_DEF = CLK_HZ / 1000 * LED_PHASE_MS;
   localparam int LED_GAP_PHASES = 4;
   localparam logic [2:0] FLASH_SEARCH = 3'h1;
   localparam logic [2:0] FLASH_CHANGED = 3'h2;
   localparam logic [2:0] FLASH_PASS = 3'h3;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } char_t;

   typedef struct packed {
      logic done;
      logic [6:0] length;
   } msg_t;

endpackage

// ### serial_rx.sv
// 8N1 receiver, LSB first, mid-bit sampling.
// Assumes rxd is already synchronous to clk, idle high.
`timescale 1ns/100ps
module serial_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bit timing
   input wire logic [15:0] bit_cyc,
   // Line and output
   input wire logic rxd,
   output gateway_pkg::char_t rx_char
);
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   rx_state_t state;
   logic [15:0] cnt;
   logic [2:0] bit_idx;
   logic [7:0] shift;

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= RX_IDLE;
         cnt <= 16'h0000;
         bit_idx <= 3'h0;
         shift <= 8'h00;
         rx_char <= '0;
      end else begin
         rx_char.valid <= 1'b0;
         case (state)
            RX_IDLE: begin
               cnt <= {1'b0, bit_cyc[15:1]};
               if (!rxd) begin
                  state <= RX_START;
               end
            end
            RX_START: begin
               if (cnt == 16'h0000) begin
                  cnt <= bit_cyc - 16'h0001;
                  bit_idx <= 3'h0;
                  state <= rxd ? RX_IDLE : RX_DATA;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            RX_DATA: begin
               if (cnt == 16'h0000) begin
                  cnt <= bit_cyc - 16'h0001;
                  shift <= {rxd, shift[7:1]};
                  if (bit_idx == 3'h7) begin
                     state <= RX_STOP;
                  end
                  bit_idx <= bit_idx + 3'h1;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            RX_STOP: begin
               if (cnt == 16'h0000) begin
                  // Framing error drops the character silently
                  rx_char.valid <= rxd;
                  rx_char.data <= shift;
                  state <= RX_IDLE;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
         endcase
      end
   end
endmodule

// ### led_blinker.sv
// Power LED sequencer: steady, off, or groups of N flashes with a pause.
// Assumes group count is held stable between groups.
`timescale 1ns/100ps
module led_blinker #(
   parameter int PHASE_CYC = gateway_pkg::LED_PHASE_CYC_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pattern
   input wire logic [2:0] flashes,
   input wire logic steady,
   // Outputs
   output logic led,
   output logic tick
);
   logic [31:0] cnt;
   logic [3:0] phase;

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt <= 32'h00000000;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == 32'(PHASE_CYC - 1));
         cnt <= (cnt == 32'(PHASE_CYC - 1)) ? 32'h00000000 : cnt + 32'h00000001;
      end
   end

   // Phases: on/off per flash, then a fixed pause
   always_ff @(posedge clk) begin
      if (reset) begin
         phase <= 4'h0;
         led <= 1'b0;
      end else if (tick) begin
         if (phase >= 4'({flashes, 1'b0}) + 4'(gateway_pkg::LED_GAP_PHASES) - 4'h1) begin
            phase <= 4'h0;
         end else begin
            phase <= phase + 4'h1;
         end
         led <= steady | ((phase < 4'({flashes, 1'b0})) & ~phase[0]);
      end else if (steady) begin
         led <= 1'b1;
      end
   end
endmodule

// ### gateway_monitor.sv
// Checker for the gateway core: mode decode, bit timing, message gating.
// Assumes it is bound to mode_switch_serial_gateway.
`timescale 1ns/100ps
module gateway_monitor #(
   parameter int LED_PHASE_CYC = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Watched outputs
   input wire gateway_pkg::mode_t active_mode,
   input wire logic proxy_enable,
   input wire logic cloning_enable,
   input wire logic gateway_enable,
   input wire logic fieldbus_enable,
   input wire logic fw_update_self,
   input wire logic pass_through,
   input wire logic [15:0] bit_cyc,
   input wire gateway_pkg::char_t msg_char,
   input wire gateway_pkg::msg_t msg_end
);
   logic [1:0] cnt;
   logic up;
   // Enables settle on the second edge after release; checks start on the fourth
   always_ff @(posedge clk) begin
      if (reset) cnt <= 2'h0;
      else if (!up) cnt <= cnt + 2'h1;
   end
   assign up = cnt == 2'h3;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_hold; up |=> $stable(active_mode); endproperty
   a_hold: assert property (p_hold) else $error("mode moved");
   property p_proxy; up |-> proxy_enable == (active_mode == gateway_pkg::MODE_PROXY)
      && cloning_enable == proxy_enable; endproperty
   a_proxy: assert property (p_proxy) else $error("proxy enables");
   property p_fast; up && active_mode == gateway_pkg::MODE_GW_FAST |->
      gateway_enable && fieldbus_enable && bit_cyc == gateway_pkg::BIT_CYC_FAST; endproperty
   a_fast: assert property (p_fast) else $error("fast gateway");
   property p_slow; up && active_mode == gateway_pkg::MODE_GW_SLOW |->
      gateway_enable && fieldbus_enable && bit_cyc == gateway_pkg::BIT_CYC_SLOW; endproperty
   a_slow: assert property (p_slow) else $error("slow gateway");
   property p_rsv; up && active_mode == gateway_pkg::MODE_RESERVED |-> !(fieldbus_enable
      | gateway_enable | proxy_enable | pass_through | fw_update_self); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved acts");
   property p_fw; up && active_mode == gateway_pkg::MODE_FW_SELF |->
      fw_update_self && !fieldbus_enable; endproperty
   a_fw: assert property (p_fw) else $error("self update");
   property p_pass; up && active_mode == gateway_pkg::MODE_PASS_THRU |->
      pass_through && !fieldbus_enable && bit_cyc == gateway_pkg::BIT_CYC_FAST; endproperty
   a_pass: assert property (p_pass) else $error("pass-through");
   property p_gate; msg_char.valid || msg_end.done |-> gateway_enable; endproperty
   a_gate: assert property (p_gate) else $error("message outside gateway");
   c_msg: cover property (msg_end.done);
   c_char: cover property (msg_char.valid);
   c_pass: cover property (up && pass_through);
endmodule

// ### sensor_model.sv
// Sensor model: frames of 8N1 characters on the serial line.
// Assumes the caller gives the cycles per bit of the selected mode.
`timescale 1ns/100ps
module sensor_model (
   // Clock
   input wire logic clk,
   // Serial line
   output logic rxd
);
   // Line rests at mark level between characters
   initial rxd = 1'b1;
   task automatic send_byte(input logic [7:0] b, input int n);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (n - 1) @(posedge clk);
      end
   endtask
   task automatic send_frame(input logic [7:0] d[$], input int n);
      send_byte(gateway_pkg::CHAR_STX, n);
      foreach (d[i]) send_byte(d[i], n);
      send_byte(gateway_pkg::CHAR_ETX, n);
   endtask
endmodule

// ### tb.sv
// Bench for the gateway core: modes, LED patterns, one gateway frame.
// Assumes sensor_model drives rxd; the checker is bound at the foot.
`timescale 1ns/100ps
module tb;
   localparam int PH = 10;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] mode_switch = 4'h0;
   logic sensor_link_up = 1'b0;
   logic [5:0] msg_mem_rd_addr = 6'h00;
   logic rxd, pass_through, proxy_enable, cloning_enable, gateway_enable;
   logic fieldbus_enable, fw_update_self, power_led, all_leds_flash;
   logic [15:0] bit_cyc;
   logic [7:0] msg_mem_rd_data;
   gateway_pkg::mode_t active_mode;
   gateway_pkg::char_t msg_char;
   gateway_pkg::msg_t msg_end;
   int error_cnt = 0;
   int num_checks = 0;
   int done_cnt = 0;
   logic [7:0] exp_q[$];
   logic [7:0] pay[$];
   gateway_pkg::mode_t m;
   always #5 clk = ~clk;
   mode_switch_serial_gateway #(.LED_PHASE_CYC(PH)) mode_switch_serial_gateway_i (
      .clk, .reset, .mode_switch, .rxd, .sensor_link_up, .pass_through, .active_mode,
      .proxy_enable, .cloning_enable, .gateway_enable, .fieldbus_enable, .fw_update_self,
      .bit_cyc, .msg_char, .msg_end, .msg_mem_rd_data, .msg_mem_rd_addr, .power_led,
      .all_leds_flash);
   sensor_model sensor_model_i (.clk, .rxd);
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic power_on(input logic [3:0] p);
      reset <= 1'b1;
      mode_switch <= p;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Window of n cycles, at least one full group period, after a settling pause
   task automatic rises(input bit sel, input int n, input int e);
      logic s, prev;
      int c;
      c = 0;
      repeat (200) @(posedge clk);
      prev = sel ? all_leds_flash : power_led;
      repeat (n) begin
         @(posedge clk);
         #1;
         s = sel ? all_leds_flash : power_led;
         c += int'(s && !prev);
         prev = s;
      end
      check(sel ? "all_leds_flash" : "power_led", 16'(e), 16'(c));
   endtask
   function automatic gateway_pkg::mode_t exp_mode(input logic [3:0] p);
      case (p)
         gateway_pkg::POS_PROXY: return gateway_pkg::MODE_PROXY;
         gateway_pkg::POS_GW_FAST: return gateway_pkg::MODE_GW_FAST;
         gateway_pkg::POS_GW_SLOW: return gateway_pkg::MODE_GW_SLOW;
         gateway_pkg::POS_FW_SELF: return gateway_pkg::MODE_FW_SELF;
         gateway_pkg::POS_PASS_THRU: return gateway_pkg::MODE_PASS_THRU;
         default: return gateway_pkg::MODE_RESERVED;
      endcase
   endfunction
   // Bits: pass, self update, gateway, fieldbus, cloning, proxy
   function automatic logic [15:0] exp_en(input gateway_pkg::mode_t k);
      case (k)
         gateway_pkg::MODE_PROXY: return 16'h0007;
         gateway_pkg::MODE_GW_FAST, gateway_pkg::MODE_GW_SLOW: return 16'h000C;
         gateway_pkg::MODE_FW_SELF: return 16'h0010;
         gateway_pkg::MODE_PASS_THRU: return 16'h0020;
         default: return 16'h0000;
      endcase
   endfunction
   always @(negedge clk) begin
      if (msg_char.valid === 1'b1) begin
         check("msg_char", exp_q.size() ? 16'(exp_q.pop_front()) : 16'h0100,
            16'(msg_char.data));
      end
      if (msg_end.done === 1'b1) begin
         done_cnt++;
         check("msg_len", 16'(pay.size()), 16'(msg_end.length));
      end
   end
   initial begin
      void'($urandom(75));
      for (int p = 0; p < 16; p++) begin
         m = exp_mode(4'(p));
         power_on(4'(p));
         mode_switch <= ~4'(p);
         repeat (3) @(posedge clk);
         #1;
         check("active_mode", 16'(m), 16'(active_mode));
         check("enables", exp_en(m), {10'h000, pass_through, fw_update_self,
            gateway_enable, fieldbus_enable, cloning_enable, proxy_enable});
         check("bit_cyc", m == gateway_pkg::MODE_GW_SLOW ? gateway_pkg::BIT_CYC_SLOW
            : gateway_pkg::BIT_CYC_FAST, bit_cyc);
      end
      rises(1'b0, 80, 2);
      power_on(gateway_pkg::POS_FW_SELF);
      rises(1'b1, 40, 2);
      power_on(gateway_pkg::POS_PASS_THRU);
      rises(1'b0, 100, 3);
      power_on(gateway_pkg::POS_PROXY);
      rises(1'b0, 60, 1);
      sensor_link_up <= 1'b1;
      rises(1'b0, 60, 0);
      check("power_led", 16'h0001, 16'(power_led));
      power_on(gateway_pkg::POS_GW_FAST);
      rises(1'b0, 60, 0);
      check("power_led", 16'h0001, 16'(power_led));
      repeat (2) pay.push_back(8'($urandom_range(255, 4)));
      exp_q = pay;
      sensor_model_i.send_frame(pay, int'(gateway_pkg::BIT_CYC_FAST));
      check("msg_done", 16'h0001, 16'(done_cnt));
      check("msg_left", 16'h0000, 16'(exp_q.size()));
      for (int i = 0; i < 2; i++) begin
         msg_mem_rd_addr <= 6'(i);
         repeat (2) @(posedge clk);
         #1;
         check("msg_mem", 16'(pay[i]), 16'(msg_mem_rd_data));
      end
      finish_test();
   end
   initial begin
      repeat (99000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule
bind mode_switch_serial_gateway gateway_monitor #(.LED_PHASE_CYC(LED_PHASE_CYC)) gateway_monitor_i (
   .clk, .reset, .active_mode, .proxy_enable, .cloning_enable, .gateway_enable,
   .fieldbus_enable, .fw_update_self, .pass_through, .bit_cyc, .msg_char, .msg_end);
